// file: hdl/pin_rise.sv
`timescale 1ns/10ps
module pin_rise import tmr_pkg::*; (
	// Clocking
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic ce,
	// Pin and edge
	input  wire logic pin,
	output logic      rise
);
	logic prev_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_r <= 1'b0;
		end else if (ce) begin
			prev_r <= pin;
		end
	end

	// Rising edge of the pin, held off by a frozen clock enable
	assign rise = ce & pin & ~prev_r;
endmodule

// file: hdl/tick_prescaler.sv
`timescale 1ns/10ps
module tick_prescaler import tmr_pkg::*; (
	// Clocking
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       ce,
	// Control
	input  wire logic       clr,
	input  wire logic       adv,
	input  wire logic [1:0] sel,
	// Divided tick
	output logic            tick
);
	logic [PS_W-1:0] cnt_r;
	logic [PS_W-1:0] cnt_nxt;
	logic            wrap;

	assign wrap = (cnt_r >= ps_limit(sel));
	assign tick = ce & adv & ~clr & wrap;

	always_comb begin
		cnt_nxt = cnt_r;
		if (clr) begin
			cnt_nxt = '0;
		end else if (adv) begin
			cnt_nxt = wrap ? '0 : cnt_r + 8'h01;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= '0;
		end else if (ce) begin
			cnt_r <= cnt_nxt;
		end
	end
endmodule

// file: hdl/timer_pair.sv
`timescale 1ns/10ps
module timer_pair import tmr_pkg::*; (
	// Clocking
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              ce,
	// Register port
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [DATA_W-1:0] wdata,
	input  wire logic              wr,
	input  wire logic              rd,
	output logic      [DATA_W-1:0] rdata,
	// Power state
	input  wire logic              idle_mode,
	input  wire logic              sleep_mode,
	// Pins
	input  wire logic              ext_clk_x,
	input  wire logic              ext_clk_y,
	input  wire logic              gate_x,
	input  wire logic              gate_y,
	// Status
	output logic                   running_x,
	output logic                   running_y
);
	logic [15:0]       ctrl_x_r;
	logic [15:0]       ctrl_y_r;
	logic [15:0]       cnt_x_r;
	logic [15:0]       cnt_y_r;
	logic [15:0]       rdata_r;
	logic              run_r_x;
	logic              run_r_y;
	logic              wr_ctrl_x;
	logic              wr_ctrl_y;
	logic              wr_cnt_x;
	logic              wr_cnt_y;
	logic              casc;
	logic              act_x;
	logic              act_y;
	logic              adv_x;
	logic              adv_y;
	logic              rise_x;
	logic              rise_y;
	logic              tick_x;
	logic              tick_y;
	logic              inc_x;
	logic              inc_y;
	src_state_t        src_x;
	src_state_t        src_y;

	assign wr_ctrl_x = wr & (addr == OFS_CTRL_X);
	assign wr_ctrl_y = wr & (addr == OFS_CTRL_Y);
	assign wr_cnt_x  = wr & (addr == OFS_CNT_X);
	assign wr_cnt_y  = wr & (addr == OFS_CNT_Y);

	// Control registers keep only implemented bits
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_x_r <= CTRL_RST;
			ctrl_y_r <= CTRL_RST;
		end else if (ce) begin
			if (wr_ctrl_x) begin
				ctrl_x_r <= wdata & CTRL_X_MASK;
			end
			if (wr_ctrl_y) begin
				ctrl_y_r <= wdata & CTRL_Y_MASK;
			end
		end
	end

	assign casc = ctrl_x_r[CASC_POS];

	// Clock source selection, per timer
	function automatic src_state_t pick_src(input logic [15:0] c, input logic sleep,
			input logic idle, input logic off);
		if (off || !c[RUN_POS]) begin
			pick_src = SRC_OFF;
		end else if (idle && c[IDLE_POS]) begin
			pick_src = SRC_OFF;
		end else if (c[SRC_POS]) begin
			pick_src = SRC_EXT;
		end else if (sleep) begin
			pick_src = SRC_OFF;
		end else begin
			pick_src = SRC_INT;
		end
	endfunction

	// Whether a source tick may reach the prescaler
	function automatic logic src_adv(input src_state_t s, input logic [15:0] c,
			input logic rise, input logic gate);
		case (s)
			SRC_EXT: src_adv = rise;
			SRC_INT: src_adv = !c[GATE_POS] || gate;
			default: src_adv = 1'b0;
		endcase
	endfunction

	assign src_x = pick_src(ctrl_x_r, sleep_mode, idle_mode, 1'b0);
	assign src_y = pick_src(ctrl_y_r, sleep_mode, idle_mode, casc);
	assign act_x = (src_x != SRC_OFF);
	assign act_y = (src_y != SRC_OFF);
	assign adv_x = src_adv(src_x, ctrl_x_r, rise_x, gate_x);
	assign adv_y = src_adv(src_y, ctrl_y_r, rise_y, gate_y);

	pin_rise u_rise_x (
		.clk  (clk),
		.rst_n(rst_n),
		.ce   (ce),
		.pin  (ext_clk_x),
		.rise (rise_x)
	);

	pin_rise u_rise_y (
		.clk  (clk),
		.rst_n(rst_n),
		.ce   (ce),
		.pin  (ext_clk_y),
		.rise (rise_y)
	);

	tick_prescaler u_ps_x (
		.clk  (clk),
		.rst_n(rst_n),
		.ce   (ce),
		.clr  (~ctrl_x_r[RUN_POS]),
		.adv  (adv_x),
		.sel  (ctrl_x_r[PS_HI:PS_LO]),
		.tick (tick_x)
	);

	tick_prescaler u_ps_y (
		.clk  (clk),
		.rst_n(rst_n),
		.ce   (ce),
		.clr  (~ctrl_y_r[RUN_POS] | casc),
		.adv  (adv_y),
		.sel  (ctrl_y_r[PS_HI:PS_LO]),
		.tick (tick_y)
	);

	assign inc_x = tick_x;
	assign inc_y = casc ? (tick_x & (cnt_x_r == CNT_FULL)) : tick_y;

	// Low word; a software write wins over a tick
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_x_r <= CNT_RST;
		end else if (ce) begin
			if (wr_cnt_x) begin
				cnt_x_r <= wdata;
			end else if (inc_x) begin
				cnt_x_r <= cnt_x_r + 16'h0001;
			end
		end
	end

	// High word, or second 16-bit timer
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_y_r <= CNT_RST;
		end else if (ce) begin
			if (wr_cnt_y) begin
				cnt_y_r <= wdata;
			end else if (inc_y) begin
				cnt_y_r <= cnt_y_r + 16'h0001;
			end
		end
	end

	// Read data stands one cycle after the strobe only
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_r <= 16'h0000;
		end else if (ce) begin
			if (rd) begin
				case (addr)
					OFS_CTRL_X: rdata_r <= ctrl_x_r;
					OFS_CTRL_Y: rdata_r <= ctrl_y_r;
					OFS_CNT_X:  rdata_r <= cnt_x_r;
					OFS_CNT_Y:  rdata_r <= cnt_y_r;
					default:    rdata_r <= 16'h0000;
				endcase
			end else begin
				rdata_r <= 16'h0000;
			end
		end
	end

	// Status flags registered
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			run_r_x <= 1'b0;
			run_r_y <= 1'b0;
		end else if (ce) begin
			run_r_x <= act_x;
			run_r_y <= act_y | (casc & act_x);
		end
	end

	assign rdata     = rdata_r;
	assign running_x = run_r_x;
	assign running_y = run_r_y;

	// Checks
	logic steady8_x;
	assign steady8_x = ce && !wr && (src_x == SRC_INT) && !ctrl_x_r[GATE_POS]
		&& (ctrl_x_r[PS_HI:PS_LO] == PS_DIV8);

	property p_stop_holds;
		@(posedge clk) disable iff (!rst_n)
		(!ctrl_x_r[RUN_POS] && !wr_cnt_x) |=> (cnt_x_r == $past(cnt_x_r));
	endproperty
	a_stop_holds: assert property (p_stop_holds) else $error("stopped timer counted");

	property p_div1_count;
		@(posedge clk) disable iff (!rst_n)
		(ce && !wr && src_x == SRC_INT && !ctrl_x_r[GATE_POS]
			&& ctrl_x_r[PS_HI:PS_LO] == PS_DIV1)
			|=> (cnt_x_r == $past(cnt_x_r) + 16'h0001);
	endproperty
	a_div1_count: assert property (p_div1_count) else $error("undivided count missed");

	property p_div8_gap;
		@(posedge clk) disable iff (!rst_n)
		(inc_x && steady8_x) ##1 steady8_x [*7] |-> (cnt_x_r == $past(cnt_x_r, 6));
	endproperty
	a_div8_gap: assert property (p_div8_gap) else $error("divide by 8 too fast");

	property p_idle_stop;
		@(posedge clk) disable iff (!rst_n)
		(idle_mode && ctrl_x_r[IDLE_POS] && !wr_cnt_x) |=> $stable(cnt_x_r);
	endproperty
	a_idle_stop: assert property (p_idle_stop) else $error("counted in idle");

	property p_sleep_int;
		@(posedge clk) disable iff (!rst_n)
		(sleep_mode && !ctrl_y_r[SRC_POS] && !casc && !wr_cnt_y) |=> $stable(cnt_y_r);
	endproperty
	a_sleep_int: assert property (p_sleep_int) else $error("internal clock ran in sleep");

	property p_sleep_ext;
		@(posedge clk) disable iff (!rst_n)
		(sleep_mode && ce && !wr && ctrl_x_r[RUN_POS] && ctrl_x_r[SRC_POS]
			&& !(idle_mode && ctrl_x_r[IDLE_POS])
			&& ctrl_x_r[PS_HI:PS_LO] == PS_DIV1 && ext_clk_x && !u_rise_x.prev_r)
			|=> (cnt_x_r == $past(cnt_x_r) + 16'h0001);
	endproperty
	a_sleep_ext: assert property (p_sleep_ext) else $error("external edge lost");

	property p_gate_low;
		@(posedge clk) disable iff (!rst_n)
		(ctrl_x_r[GATE_POS] && !ctrl_x_r[SRC_POS] && !gate_x && !wr_cnt_x)
			|=> $stable(cnt_x_r);
	endproperty
	a_gate_low: assert property (p_gate_low) else $error("counted with gate low");

	property p_carry;
		@(posedge clk) disable iff (!rst_n)
		(casc && tick_x && cnt_x_r == CNT_FULL && !wr)
			|=> (cnt_y_r == $past(cnt_y_r) + 16'h0001) && (cnt_x_r == 16'h0000);
	endproperty
	a_carry: assert property (p_carry) else $error("cascade carry lost");

	property p_casc_y_quiet;
		@(posedge clk) disable iff (!rst_n)
		(casc && !(tick_x && cnt_x_r == CNT_FULL) && !wr_cnt_y) |=> $stable(cnt_y_r);
	endproperty
	a_casc_y_quiet: assert property (p_casc_y_quiet) else $error("high word ran alone");

	property p_ctrl_read;
		@(posedge clk) disable iff (!rst_n)
		(ce && rd && addr == OFS_CTRL_X && !wr)
			|=> (rdata == $past(ctrl_x_r)) && ((rdata & ~CTRL_X_MASK) == 16'h0000);
	endproperty
	a_ctrl_read: assert property (p_ctrl_read) else $error("control readback wrong");

	property p_freeze;
		@(posedge clk) disable iff (!rst_n)
		!ce |=> $stable(cnt_x_r) && $stable(cnt_y_r) && $stable(ctrl_x_r) && $stable(rdata);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved while frozen");

	property p_y_div1_count;
		@(posedge clk) disable iff (!rst_n)
		(ce && !wr && !casc && src_y == SRC_INT && !ctrl_y_r[GATE_POS]
			&& ctrl_y_r[PS_HI:PS_LO] == PS_DIV1)
			|=> (cnt_y_r == $past(cnt_y_r) + 16'h0001);
	endproperty
	a_y_div1_count: assert property (p_y_div1_count) else $error("second timer missed a count");

	property p_ext_quiet;
		@(posedge clk) disable iff (!rst_n)
		(ctrl_x_r[SRC_POS] && !rise_x && !wr_cnt_x) |=> $stable(cnt_x_r);
	endproperty
	a_ext_quiet: assert property (p_ext_quiet) else $error("counted without pin edge");

	c_div8: cover property (@(posedge clk) disable iff (!rst_n) inc_x && steady8_x);
	c_carry: cover property (@(posedge clk) disable iff (!rst_n) inc_y && casc);
	c_ext: cover property (@(posedge clk) disable iff (!rst_n) inc_x && src_x == SRC_EXT);
	c_gated: cover property (@(posedge clk) disable iff (!rst_n)
		inc_x && ctrl_x_r[GATE_POS] && !ctrl_x_r[SRC_POS]);
endmodule

// file: hdl/tmr_pkg.sv
// Behaviour
// - Run bit starts and stops the timer.
// - Cascade bit joins pair into 32-bit timer.
// - Idle-stop bit halts timer during Idle.
// - Clock-source bit picks pin edges or clock.
// - Gate-enable turns gated accumulation on, internal.
// - External source ignores gate-enable bit.
// - Unused control bits ignore writes, read zero.
// - Sleep stops timer on internal clock.
// - Sleep lets externally clocked timer count.
// - Idle-stop bit sits at bit 13.
package tmr_pkg;
	localparam int unsigned ADDR_W   = 3;
	localparam int unsigned DATA_W   = 16;
	localparam int unsigned PS_W     = 8;

	localparam logic [2:0] OFS_CTRL_X = 3'h0;
	localparam logic [2:0] OFS_CTRL_Y = 3'h1;
	localparam logic [2:0] OFS_CNT_X  = 3'h2;
	localparam logic [2:0] OFS_CNT_Y  = 3'h3;

	localparam int unsigned RUN_POS   = 15;
	localparam int unsigned IDLE_POS  = 13;
	localparam int unsigned GATE_POS  = 6;
	localparam int unsigned PS_HI     = 5;
	localparam int unsigned PS_LO     = 4;
	localparam int unsigned CASC_POS  = 3;
	localparam int unsigned SRC_POS   = 1;

	localparam logic [15:0] CTRL_X_MASK = 16'hA07A;
	localparam logic [15:0] CTRL_Y_MASK = 16'hA072;
	localparam logic [15:0] CTRL_RST    = 16'h0000;
	localparam logic [15:0] CNT_RST     = 16'h0000;
	localparam logic [15:0] CNT_FULL    = 16'hFFFF;

	localparam logic [1:0] PS_DIV1   = 2'h0;
	localparam logic [1:0] PS_DIV8   = 2'h1;
	localparam logic [1:0] PS_DIV64  = 2'h2;
	localparam logic [1:0] PS_DIV256 = 2'h3;

	localparam logic [7:0] PS_LIM1   = 8'h00;
	localparam logic [7:0] PS_LIM8   = 8'h07;
	localparam logic [7:0] PS_LIM64  = 8'h3F;
	localparam logic [7:0] PS_LIM256 = 8'hFF;

	typedef enum logic [1:0] {SRC_OFF, SRC_INT, SRC_EXT} src_state_t;

	function automatic logic [7:0] ps_limit(input logic [1:0] sel);
		case (sel)
			PS_DIV8:   ps_limit = PS_LIM8;
			PS_DIV64:  ps_limit = PS_LIM64;
			PS_DIV256: ps_limit = PS_LIM256;
			default:   ps_limit = PS_LIM1;
		endcase
	endfunction
endpackage

// file: sim/pin_model.sv
`timescale 1ns/10ps
module pin_model (
	// Clocking
	input  wire logic clk,
	input  wire logic rst_n,
	// Control
	input  wire logic clk_on,
	input  wire logic gate_on,
	// Pins
	output logic      ext_clk,
	output logic      gate
);
	logic [1:0] ph_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ph_r <= 2'h0;
		end else begin
			ph_r <= ph_r + 2'h1;
		end
	end

	// One rise per four cycles, pins still while off
	assign ext_clk = clk_on & ph_r[1];
	assign gate    = gate_on & ph_r[1];
endmodule

// file: sim/timer_pair_tb.sv
`timescale 1ns/10ps
module timer_pair_tb import tmr_pkg::*;;
	localparam int SPAN = 512;
	logic              clk     = 1'b0;
	logic              rst_n   = 1'b0;
	logic [ADDR_W-1:0] addr    = '0;
	logic [DATA_W-1:0] wdata   = '0;
	logic              wr      = 1'b0;
	logic              rd      = 1'b0;
	logic              ce      = 1'b1;
	logic              idle    = 1'b0;
	logic              slp     = 1'b0;
	logic              clk_on  = 1'b0;
	logic              gate_on = 1'b0;
	logic [DATA_W-1:0] rdata;
	logic [DATA_W-1:0] a;
	logic [DATA_W-1:0] b;
	logic [DATA_W-1:0] d;
	logic [DATA_W-1:0] r;
	logic              run_x;
	logic              run_y;
	logic              ext_clk;
	logic              gate;
	int                mismatches  = 0;
	int                check_count = 0;
	int                seed        = 32'h155d;

	always #50 clk = ~clk;

	timer_pair dut (
		.clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .idle_mode(idle), .sleep_mode(slp),
		.ext_clk_x(ext_clk), .ext_clk_y(ext_clk), .gate_x(gate), .gate_y(gate),
		.running_x(run_x), .running_y(run_y)
	);

	pin_model pm (
		.clk(clk), .rst_n(rst_n), .clk_on(clk_on), .gate_on(gate_on),
		.ext_clk(ext_clk), .gate(gate)
	);

	function automatic logic [15:0] mk(input logic idl, input logic gt,
			input logic [1:0] ps, input logic cs, input logic src);
		mk = 16'h8000;
		mk[13] = idl;
		mk[6] = gt;
		mk[5:4] = ps;
		mk[3] = cs;
		mk[1] = src;
	endfunction

	function automatic logic [15:0] div_cnt(input logic [1:0] ps);
		div_cnt = 16'(SPAN >> ((ps == 2'h0) ? 0 : (ps == 2'h1) ? 3 : (ps == 2'h2) ? 6 : 8));
	endfunction

	task automatic wr_reg(input logic [2:0] ad, input logic [15:0] v);
		@(posedge clk);
		addr <= ad;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [2:0] ad, output logic [15:0] v);
		@(posedge clk);
		addr <= ad;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Count advance between two reads SPAN cycles apart
	task automatic meas(input logic [2:0] ad, output logic [15:0] v);
		rd_reg(ad, a);
		repeat (SPAN - 2) @(posedge clk);
		rd_reg(ad, b);
		v = b - a;
	endtask

	task automatic tally_and_finish();
		if (mismatches == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	initial begin
		#(20000 * 100);
		mismatches++;
		tally_and_finish();
	end

	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			wr_reg(3'(i | 4), 16'hFFFF);
			rd_reg(3'(i), a);
			chk("reset_or_unmapped", 16'h0000, a);
		end
		for (int i = 0; i < 6; i++) begin
			r = 16'($random(seed));
			wr_reg(OFS_CTRL_X, r);
			rd_reg(OFS_CTRL_X, a);
			chk("ctrl_x", r & 16'hA07A, a);
			wr_reg(OFS_CTRL_Y, ~r);
			rd_reg(OFS_CTRL_Y, a);
			chk("ctrl_y", ~r & 16'hA072, a);
		end
		wr_reg(OFS_CTRL_Y, 16'h0000);
		wr_reg(OFS_CTRL_X, 16'h2000);
		rd_reg(OFS_CTRL_X, a);
		chk("idle_bit", 16'h2000, a);
		for (int p = 0; p < 4; p++) begin
			wr_reg(OFS_CTRL_X, mk(1'b0, 1'b0, 2'(p), 1'b0, 1'b0));
			meas(OFS_CNT_X, d);
			chk("cnt_x_rate", div_cnt(2'(p)), d);
		end
		chk("running_x", 16'h0001, {15'h0, run_x});
		wr_reg(OFS_CTRL_X, 16'h0000);
		meas(OFS_CNT_X, d);
		chk("cnt_x_stopped", 16'h0000, d);
		chk("running_x", 16'h0000, {15'h0, run_x});
		wr_reg(OFS_CTRL_Y, mk(1'b0, 1'b0, 2'h0, 1'b0, 1'b0));
		meas(OFS_CNT_Y, d);
		chk("cnt_y_alone", 16'(SPAN), d);
		wr_reg(OFS_CTRL_Y, 16'h0000);
		wr_reg(OFS_CNT_X, 16'hFFF0);
		wr_reg(OFS_CNT_Y, 16'h0005);
		wr_reg(OFS_CTRL_X, mk(1'b0, 1'b0, 2'h0, 1'b1, 1'b0));
		repeat (30) @(posedge clk);
		chk("running_y", 16'h0001, {15'h0, run_y});
		wr_reg(OFS_CTRL_X, 16'h0000);
		rd_reg(OFS_CNT_Y, a);
		chk("cnt_y_carry", 16'h0006, a);
		idle <= 1'b1;
		wr_reg(OFS_CTRL_X, mk(1'b1, 1'b0, 2'h0, 1'b0, 1'b0));
		meas(OFS_CNT_X, d);
		chk("idle_stop", 16'h0000, d);
		wr_reg(OFS_CTRL_X, mk(1'b0, 1'b0, 2'h0, 1'b0, 1'b0));
		meas(OFS_CNT_X, d);
		chk("idle_run", 16'(SPAN), d);
		idle <= 1'b0;
		slp <= 1'b1;
		meas(OFS_CNT_X, d);
		chk("sleep_int", 16'h0000, d);
		wr_reg(OFS_CTRL_X, mk(1'b0, 1'b1, 2'h0, 1'b0, 1'b1));
		meas(OFS_CNT_X, d);
		chk("ext_pin_still", 16'h0000, d);
		clk_on <= 1'b1;
		meas(OFS_CNT_X, d);
		chk("sleep_ext", 16'(SPAN / 4), d);
		slp <= 1'b0;
		clk_on <= 1'b0;
		wr_reg(OFS_CTRL_X, mk(1'b0, 1'b1, 2'h0, 1'b0, 1'b0));
		meas(OFS_CNT_X, d);
		chk("gate_low", 16'h0000, d);
		gate_on <= 1'b1;
		meas(OFS_CNT_X, d);
		chk("gate_half", 16'(SPAN / 2), d);
		wr_reg(OFS_CTRL_X, mk(1'b0, 1'b0, 2'h0, 1'b0, 1'b0));
		meas(OFS_CNT_X, d);
		chk("gate_off", 16'(SPAN), d);
		rd_reg(OFS_CNT_X, a);
		@(posedge clk);
		ce <= 1'b0;
		repeat (100) @(posedge clk);
		ce <= 1'b1;
		repeat (SPAN - 103) @(posedge clk);
		rd_reg(OFS_CNT_X, b);
		chk("cnt_x_frozen", 16'(SPAN - 100), b - a);
		tally_and_finish();
	end
endmodule
